// file: logic/scl_pkg.sv
package scl_pkg;

  // ----------------------------------------
  // Geometry and map
  // ----------------------------------------
  localparam int          LANES      = 4;
  localparam int          AW         = 8;
  localparam logic [7:0]  RX_BASE    = 8'h00;  // Four rx words
  localparam logic [7:0]  TX_BASE    = 8'h10;  // Four tx words
  localparam logic [7:0]  MAP_END    = 8'h20;
  localparam logic [31:0] RX_WMASK   = 32'h007f_f7fd;
  localparam logic [31:0] TX_WMASK   = 32'h0001_ffff;
  localparam logic [31:0] RX_RST     = 32'h0000_0000;
  localparam logic [31:0] TX_RST     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // ----------------------------------------
  // Field codes and lane timing
  // ----------------------------------------
  localparam logic [1:0]  RATE_FULL  = 2'h0;
  localparam logic [1:0]  RATE_HALF  = 2'h1;
  localparam logic [1:0]  RATE_QUART = 2'h2;
  localparam logic [2:0]  WIDTH_10   = 3'h0;
  localparam logic [2:0]  WIDTH_8    = 3'h1;
  localparam logic [3:0]  BITS_10    = 4'ha;
  localparam logic [3:0]  BITS_8     = 4'h8;
  localparam logic [3:0]  BCLK_HIGH  = 4'h4;
  localparam logic [1:0]  DIV_QUART  = 2'h3;

  typedef struct packed {
    logic [8:0]  rsvd_hi;
    logic [10:0] rx_misc;
    logic        rsvd11;
    logic [2:0]  term_sel;
    logic        polarity_swap;
    logic [1:0]  rate;
    logic [2:0]  parallel_width_sel;
    logic        rsvd1;
    logic        rx_lane_on;
  } scl_rx_cfg_t;

  typedef struct packed {
    logic [14:0] rsvd_hi;
    logic        fixed_phase_sel;
    logic [3:0]  deemphasis_level;
    logic [2:0]  swing_level;
    logic        common_mode_raise;
    logic        polarity_swap;
    logic [1:0]  rate;
    logic [2:0]  parallel_width_sel;
    logic        rsvd1;
    logic        tx_lane_on;
  } scl_tx_cfg_t;

endpackage : scl_pkg

// file: logic/scl_lane_cfg.sv
module scl_lane_cfg (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [7:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [3:0]                     rx_pos_pin,
  input  wire logic [3:0]                     rx_neg_pin,
  output logic [3:0][9:0]                     rx_parallel_word,
  output logic [3:0]                          rx_byte_clock,
  output scl_pkg::scl_tx_cfg_t [3:0]          tx_cfg
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge of a write into a register, masked to writable bits
  function automatic logic [31:0] scl_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r & msk;
  endfunction : scl_merge

  // True when the address hits one of the eight config words
  function automatic logic scl_hit(input logic [7:0] a);
    return (a < scl_pkg::MAP_END) && (a[1:0] == 2'h0);
  endfunction : scl_hit

  // ----------------------------------------
  // Register and bus state
  // ----------------------------------------
  scl_pkg::scl_rx_cfg_t [3:0] rx_cfg_reg, rx_cfg_next;
  scl_pkg::scl_tx_cfg_t [3:0] tx_cfg_reg, tx_cfg_next;
  logic        aw_have_reg, aw_have_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_have_reg,  w_have_next;
  logic [31:0] w_data_reg,  w_data_next;
  logic [3:0]  w_strb_reg,  w_strb_next;
  logic        awready_reg, awready_next;
  logic        wready_reg,  wready_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;

  // Write and read channels; address and data may arrive in either order
  always_comb begin
    rx_cfg_next  = rx_cfg_reg;
    tx_cfg_next  = tx_cfg_reg;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = scl_hit(aw_addr_reg) ? scl_pkg::RESP_OKAY : scl_pkg::RESP_SLV;
      if (scl_hit(aw_addr_reg) && !aw_addr_reg[4]) begin
        // Reserved bit 1 is masked off, so a careless write cannot set it
        rx_cfg_next[aw_addr_reg[3:2]] = scl_merge(rx_cfg_reg[aw_addr_reg[3:2]], w_data_reg,
                                                  w_strb_reg, scl_pkg::RX_WMASK);
      end else if (scl_hit(aw_addr_reg)) begin
        tx_cfg_next[aw_addr_reg[3:2]] = scl_merge(tx_cfg_reg[aw_addr_reg[3:2]], w_data_reg,
                                                  w_strb_reg, scl_pkg::TX_WMASK);
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = scl_hit(s_axi_araddr) ? scl_pkg::RESP_OKAY : scl_pkg::RESP_SLV;
      if (!scl_hit(s_axi_araddr)) begin
        rdata_next = 32'h0000_0000;
      end else if (!s_axi_araddr[4]) begin
        rdata_next = rx_cfg_reg[s_axi_araddr[3:2]];
      end else begin
        rdata_next = tx_cfg_reg[s_axi_araddr[3:2]];
      end
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // Bus and config registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cfg_reg  <= {scl_pkg::LANES{scl_pkg::RX_RST}};
      tx_cfg_reg  <= {scl_pkg::LANES{scl_pkg::TX_RST}};
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'h0;
    end else begin
      rx_cfg_reg  <= rx_cfg_next;
      tx_cfg_reg  <= tx_cfg_next;
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign tx_cfg        = tx_cfg_reg;

  // ----------------------------------------
  // Receive lanes
  // ----------------------------------------
  logic [3:0]       pos_m_reg, pos_s_reg, neg_m_reg, neg_s_reg;
  logic [1:0]       div_reg, div_next;
  logic [3:0]       strobe;
  logic [3:0][9:0]  sr_reg, sr_next;
  logic [3:0][3:0]  cnt_reg, cnt_next;
  logic [3:0][9:0]  word_reg, word_next;
  logic [3:0]       bclk_reg, bclk_next;
  logic [3:0]       settle_reg, settle_next, run_reg, run_next; // Lane 0 helpers for the byte clock check

  // Two-flop synchronisers on the receive pins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pos_m_reg <= 4'h0;
      pos_s_reg <= 4'h0;
      neg_m_reg <= 4'hf;
      neg_s_reg <= 4'hf;
    end else begin
      pos_m_reg <= rx_pos_pin;
      pos_s_reg <= pos_m_reg;
      neg_m_reg <= rx_neg_pin;
      neg_s_reg <= neg_m_reg;
    end
  end

  // Sample strobes: ref_clk stands for the doubled PLL rate, so full rate samples every cycle
  always_comb begin
    div_next = div_reg + 2'h1;
    for (int l = 0; l < scl_pkg::LANES; l++) begin
      unique case (rx_cfg_reg[l].rate)
        scl_pkg::RATE_FULL:  strobe[l] = 1'b1;
        scl_pkg::RATE_HALF:  strobe[l] = div_reg[0];
        scl_pkg::RATE_QUART: strobe[l] = (div_reg == scl_pkg::DIV_QUART);
        default:             strobe[l] = 1'b0;                           // Reserved code halts the lane
      endcase
    end
  end

  // Word assembly, LSB first; a narrow word reuses the previous byte's low bits on top
  always_comb begin
    sr_next   = sr_reg;
    cnt_next  = cnt_reg;
    word_next = word_reg;
    bclk_next = bclk_reg;
    for (int l = 0; l < scl_pkg::LANES; l++) begin
      if (!rx_cfg_reg[l].rx_lane_on) begin
        sr_next[l]   = 10'h000;
        cnt_next[l]  = 4'h0;
        word_next[l] = 10'h000;
        bclk_next[l] = 1'b0;
      end else if (strobe[l]) begin
        // Swap picks the negative leg as true data
        sr_next[l] = {(rx_cfg_reg[l].polarity_swap ? neg_s_reg[l] : pos_s_reg[l]), sr_reg[l][9:1]};
        if (rx_cfg_reg[l].parallel_width_sel == scl_pkg::WIDTH_8) begin
          if (cnt_reg[l] >= scl_pkg::BITS_8 - 4'h1) begin // A late switch from ten bits wraps at once
            cnt_next[l]  = 4'h0;
            word_next[l] = {word_reg[l][1:0], sr_next[l][9:2]};
          end else begin
            cnt_next[l] = cnt_reg[l] + 4'h1;
          end
        end else begin
          // Reserved widths fall back to ten bits
          if (cnt_reg[l] >= scl_pkg::BITS_10 - 4'h1) begin
            cnt_next[l]  = 4'h0;
            word_next[l] = sr_next[l];
          end else begin
            cnt_next[l] = cnt_reg[l] + 4'h1;
          end
        end
        bclk_next[l] = (cnt_next[l] < scl_pkg::BCLK_HIGH);
      end
    end
    // Lane 0 mode settle time and byte clock run length, both saturating; a swap change does not count
    settle_next = (rx_cfg_next[0][6:0] != rx_cfg_reg[0][6:0]) ? 4'h0 : settle_reg + 4'(settle_reg != 4'hf);
    run_next    = (bclk_next[0] != bclk_reg[0]) ? 4'h1 : run_reg + 4'(run_reg != 4'hf);
  end

  // Lane registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_reg  <= 2'h0;
      sr_reg   <= '0;
      cnt_reg  <= '0;
      word_reg <= '0;
      bclk_reg <= 4'h0;
      settle_reg <= 4'h0;
      run_reg  <= 4'h1;
    end else begin
      div_reg  <= div_next;
      sr_reg   <= sr_next;
      cnt_reg  <= cnt_next;
      word_reg <= word_next;
      bclk_reg <= bclk_next;
      settle_reg <= settle_next;
      run_reg  <= run_next;
    end
  end

  assign rx_parallel_word = word_reg;
  assign rx_byte_clock    = bclk_reg;

  // ----------------------------------------
  // Checks on lane 0 and the bus
  // ----------------------------------------
  AST_SWAP_LEG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_cfg_reg[0].rx_lane_on && strobe[0] |=>
      sr_reg[0][9] == ($past(rx_cfg_reg[0].polarity_swap) ? $past(neg_s_reg[0]) : $past(pos_s_reg[0])))
    else $error("Lane 0 sampled the wrong leg");

  AST_RATE_HALF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_cfg_reg[0].rate == scl_pkg::RATE_HALF && strobe[0] |=> !strobe[0] ##1 strobe[0])
    else $error("Half rate strobe not every second cycle");

  AST_RATE_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_cfg_reg[0].rx_lane_on && rx_cfg_reg[0].rate == 2'h3 |=> $stable(cnt_reg[0]))
    else $error("Reserved rate moved the lane");

  AST_W10_CLK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    settle_reg == 4'hf && rx_cfg_reg[0].rate == scl_pkg::RATE_FULL && rx_cfg_reg[0].rx_lane_on
      && rx_cfg_reg[0].parallel_width_sel == scl_pkg::WIDTH_10 && bclk_next[0] != bclk_reg[0]
      |-> run_reg == (bclk_reg[0] ? scl_pkg::BCLK_HIGH : scl_pkg::BITS_10 - scl_pkg::BCLK_HIGH))
    else $error("Ten-bit byte clock not 4 high 6 low");

  AST_W8_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_cfg_reg[0].rx_lane_on && rx_cfg_reg[0].parallel_width_sel == scl_pkg::WIDTH_8
      && strobe[0] && cnt_reg[0] == 4'h7 |=> word_reg[0][9:8] == $past(word_reg[0][1:0]))
    else $error("Byte mode top lines not previous low bits");

  AST_LANE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rx_cfg_reg[0].rx_lane_on |=> !bclk_reg[0] && word_reg[0] == 10'h000)
    else $error("Disabled lane still active");

  AST_TX_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rvalid_reg && rresp_reg == scl_pkg::RESP_OKAY && $rose(rvalid_reg)
      && $past(s_axi_araddr[4]) |-> rdata_reg[31:17] == 15'h0000)
    else $error("Transmit reserved bits read nonzero");

  AST_RX_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    aw_have_reg && w_have_reg && !bvalid_reg && aw_addr_reg == scl_pkg::RX_BASE && w_strb_reg == 4'hf
      |=> rx_cfg_reg[0] == (w_data_reg & scl_pkg::RX_WMASK) ##0 bvalid_reg)
    else $error("Receive config write not stored");

  AST_TX_LANE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    aw_have_reg && w_have_reg && !bvalid_reg && aw_addr_reg == scl_pkg::TX_BASE
      |=> $stable(tx_cfg_reg[1]) && $stable(tx_cfg_reg[3]))
    else $error("Transmit write touched another port");

endmodule : scl_lane_cfg

// file: sim/test_serdes_lane_config_regs.sv
module test_serdes_lane_config_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic                       ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic                       awready, wready, bvalid, arready, rvalid;
  logic [7:0]                 awaddr, araddr;
  logic [31:0]                wdata, rdata;
  logic [3:0]                 wstrb, pos, neg, bclk;
  logic [1:0]                 bresp, rresp;
  logic [3:0][9:0]            word;
  scl_pkg::scl_tx_cfg_t [3:0] txc;
  logic [31:0]                mir [8];
  logic [33:0]                rq [$];
  logic [1:0]                 bq [$];
  int                         mismatches, total_checks, cyc, seed, k;

  scl_lane_cfg dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_pos_pin(pos), .rx_neg_pin(neg), .rx_parallel_word(word), .rx_byte_clock(bclk),
    .tx_cfg(txc)
  );

  // 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task print_verdict;
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Address and data offered together; each dropped on its own handshake
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    if (r == scl_pkg::RESP_OKAY) mir[a[4:2]] = d & (a[4] ? scl_pkg::TX_WMASK : scl_pkg::RX_WMASK);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge ref_clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (!rvalid);
    rready  <= 1'b0;
  endtask : rd

  // Constant pin levels make the word independent of where the bit counter stood
  task lane(input int l, input logic [7:0] c, input logic p, input logic n, input logic [9:0] w, input int h);
    logic [31:0] d;
    int          hi;
    d      = $random(seed);
    d[7:0] = c;
    d[1]   = 1'b0;
    wr(8'(4 * l), d, scl_pkg::RESP_OKAY);
    pos <= {4{p}};
    neg <= {4{n}};
    rd(8'(4 * l), {scl_pkg::RESP_OKAY, mir[l]});
    repeat (100) @(posedge ref_clk);
    hi = 0;
    repeat (80) begin
      @(posedge ref_clk);
      if (bclk[l] === 1'b1) hi++;
    end
    chk("byte_clock_high", 34'(h), 34'(hi));
    chk("word", {24'h0, w}, {24'h0, word[l]});
  endtask : lane

  // ----------------------------------------
  // Response monitor and hang guard
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed    = 69;
    rst_n   = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    pos     = 4'h0;
    neg     = 4'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      mir[i] = (i < 4) ? scl_pkg::RX_RST : scl_pkg::TX_RST;
      rd(8'(4 * i), {scl_pkg::RESP_OKAY, mir[i]});
    end
    chk("tx_cfg_reset", {2'h0, scl_pkg::TX_RST}, {2'h0, txc[0]});
    // Random lanes so that a shared store would show as cross-talk
    repeat (8) begin
      k = $random(seed) & 3;
      wr(8'(8'h10 + 4 * k), $random(seed), scl_pkg::RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h10 + 4 * i), {scl_pkg::RESP_OKAY, mir[4 + i]});
      chk("tx_cfg", {2'h0, mir[4 + i]}, {2'h0, txc[i]});
    end
    // Unmapped and unaligned places answer with an error and change nothing
    wr(8'h20, 32'hffff_ffff, scl_pkg::RESP_SLV);
    wr(8'h12, 32'hffff_ffff, scl_pkg::RESP_SLV);
    rd(8'h24, {scl_pkg::RESP_SLV, 32'h0});
    rd(8'h10, {scl_pkg::RESP_OKAY, mir[4]});
    lane(0, 8'h01, 1'b1, 1'b0, 10'h3ff, 32);
    lane(0, 8'h81, 1'b1, 1'b0, 10'h000, 32);
    lane(3, 8'h81, 1'b1, 1'b1, 10'h3ff, 32);
    lane(3, 8'h05, 1'b1, 1'b0, 10'h3ff, 40);
    lane(1, 8'h21, 1'b1, 1'b0, 10'h3ff, 32);
    lane(0, 8'h05, 1'b1, 1'b0, 10'h3ff, 40);
    lane(0, 8'h21, 1'b1, 1'b0, 10'h3ff, 32);
    lane(2, 8'h41, 1'b1, 1'b0, 10'h3ff, 32);
    lane(2, 8'h00, 1'b1, 1'b0, 10'h000, 0);
    print_verdict();
  end

endmodule : test_serdes_lane_config_regs
